// File: rtl/adc_cfg_map.svh
/*
  Register offsets, field positions, reset values and limits of the
  output configuration register bank.
  Assumes nothing; definitions only.
*/
`ifndef ADC_CFG_MAP_SVH
`define ADC_CFG_MAP_SVH

// register offsets
`define OFS_TERM 8'h15
`define OFS_PHASE 8'h16
`define OFS_W1_LO 8'h19
`define OFS_W1_HI 8'h1A
`define OFS_W2_LO 8'h1B
`define OFS_W2_HI 8'h1C
`define OFS_ORDER 8'h21
`define OFS_LANE 8'h22

// field positions
`define TERM_LSB 4
`define TERM_MSB 5
`define PHASE_MSB 3
`define ORDER_BIT 7
`define LANE_PD_BIT 0
`define LANE_RST_BIT 1

// reset values
`define RST_TERM 2'h0
`define RST_PHASE 4'h3
`define RST_WORD 8'h00
`define RST_ORDER 1'h0
`define RST_LANE 1'h0

// limits and codes
`define PHASE_MAX 4'hA
`define TEST_USER 4'h8

`endif

// File: rtl/adc_cfg_pkg.sv
/*
  Types shared by the output configuration register bank.
  Assumes the map header supplies the numeric constants.
*/
package adc_cfg_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [7:0] reg_addr_t;
  typedef logic [3:0] phase_code_t;
  typedef logic [1:0] term_code_t;
endpackage

// File: rtl/adc_output_config_regs.sv
/*
  Output configuration registers of a multi-channel converter: output
  termination, output clock phase, two user test words, bit order and
  per-channel power-down and output reset, plus the output data mux.
  Assumes the serial control port decoder runs on the same clock and
  presents one-cycle write and read strobes with an address; channel
  select and test mode come from registers held elsewhere.
*/
//
// Functional notes
// - termination field is two bits, 00 means none, reset 00.
// - phase field is four bits, 60 degree steps, codes 0000 to 1010.
// - phase field resets to 0011, i.e. 180 degrees.
// - phase only picks the output clock phase, never sample latching.
// - two 16-bit user words in low and high bytes, all reset to zero.
// - top bit of bit order register sends LSB first on all channels.
// - lane bit 0 powers down the selected channels, default off.
// - lane bit 1 holds the selected channels' output in reset.
// - test mode user input puts the user words on the outputs.
`timescale 1ns/100ps
`include "adc_cfg_map.svh"

module adc_output_config_regs
  import adc_cfg_pkg::*;
#(
  parameter int CHANNELS = 4,
  parameter int DATA_W = 12
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // register port from serial control decoder
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire reg_addr_t reg_addr,
  input wire reg_byte_t reg_wdata,
  output reg_byte_t reg_rdata,
  output logic reg_rvalid,
  // settings held elsewhere
  input wire logic [CHANNELS-1:0] chan_select,
  input wire logic [3:0] test_mode,
  input wire logic test_alternate,
  // converted samples
  input wire logic sample_valid,
  input wire logic [CHANNELS*DATA_W-1:0] sample_data,
  // configuration outputs
  output term_code_t term_select,
  output phase_code_t clock_phase,
  output logic lsb_first,
  output logic [CHANNELS-1:0] chan_powerdown,
  output logic [CHANNELS-1:0] chan_out_reset,
  // output words towards serializers
  output logic out_valid,
  output logic [CHANNELS*DATA_W-1:0] out_data
);

  // refuse sizes the lane readback and the word mux cannot serve
  if (CHANNELS < 1 || CHANNELS > 8 ||
      DATA_W < 1 || DATA_W > 16) begin : g_bad_size
    $error("unsupported channel count or data width");
  end

  // address match, used for both writes and reads
  function automatic logic hit(input reg_addr_t a, input reg_addr_t ofs);
    hit = (a == ofs);
  endfunction

  // bit reversal over the data width
  function automatic logic [DATA_W-1:0] flip(input logic [DATA_W-1:0] v);
    for (int i = 0; i < DATA_W; i++) begin
      flip[i] = v[DATA_W-1-i];
    end
  endfunction

  // reset release through two flops
  logic rst_s1_q;
  logic rst_n_q;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  logic wr_ok;
  assign wr_ok = reg_wr;

  term_code_t term_q;
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      term_q <= `RST_TERM;
    end else if (wr_ok && hit(reg_addr, `OFS_TERM)) begin
      term_q <= reg_wdata[`TERM_MSB:`TERM_LSB];
    end
  end

  // phase select, codes above the top step are dropped
  phase_code_t phase_q;
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      phase_q <= `RST_PHASE;
    end else if (wr_ok && hit(reg_addr, `OFS_PHASE) &&
                 reg_wdata[`PHASE_MSB:0] <= `PHASE_MAX) begin
      phase_q <= reg_wdata[`PHASE_MSB:0];
    end
  end

  // user test words, one byte per register
  logic [15:0] word1_q;
  logic [15:0] word2_q;
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      word1_q <= {`RST_WORD, `RST_WORD};
      word2_q <= {`RST_WORD, `RST_WORD};
    end else if (wr_ok) begin
      if (hit(reg_addr, `OFS_W1_LO)) word1_q[7:0] <= reg_wdata;
      if (hit(reg_addr, `OFS_W1_HI)) word1_q[15:8] <= reg_wdata;
      if (hit(reg_addr, `OFS_W2_LO)) word2_q[7:0] <= reg_wdata;
      if (hit(reg_addr, `OFS_W2_HI)) word2_q[15:8] <= reg_wdata;
    end
  end

  logic order_q;
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      order_q <= `RST_ORDER;
    end else if (wr_ok && hit(reg_addr, `OFS_ORDER)) begin
      order_q <= reg_wdata[`ORDER_BIT];
    end
  end

  // per-channel lane bits, only selected channels change
  logic [CHANNELS-1:0] pd_q;
  logic [CHANNELS-1:0] ors_q;
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_lane
      always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
          pd_q[g] <= `RST_LANE;
          ors_q[g] <= `RST_LANE;
        end else if (wr_ok && hit(reg_addr, `OFS_LANE) &&
                     chan_select[g]) begin
          pd_q[g] <= reg_wdata[`LANE_PD_BIT];
          ors_q[g] <= reg_wdata[`LANE_RST_BIT];
        end
      end
    end
  endgenerate

  // lane readback shows the lowest selected channel
  logic [1:0] lane_rd;
  always_comb begin
    lane_rd = 2'h0;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (chan_select[i]) lane_rd = {ors_q[i], pd_q[i]};
    end
  end

  // read data registered one cycle after the strobe, unmapped read 00
  reg_byte_t rd_d;
  always_comb begin
    rd_d = 8'h00;
    if (hit(reg_addr, `OFS_TERM)) rd_d[`TERM_MSB:`TERM_LSB] = term_q;
    if (hit(reg_addr, `OFS_PHASE)) rd_d[`PHASE_MSB:0] = phase_q;
    if (hit(reg_addr, `OFS_W1_LO)) rd_d = word1_q[7:0];
    if (hit(reg_addr, `OFS_W1_HI)) rd_d = word1_q[15:8];
    if (hit(reg_addr, `OFS_W2_LO)) rd_d = word2_q[7:0];
    if (hit(reg_addr, `OFS_W2_HI)) rd_d = word2_q[15:8];
    if (hit(reg_addr, `OFS_ORDER)) rd_d[`ORDER_BIT] = order_q;
    if (hit(reg_addr, `OFS_LANE)) rd_d[1:0] = lane_rd;
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) reg_rdata <= rd_d;
    end
  end

  // configuration outputs straight from the registers
  assign term_select = term_q;
  // phase leaves the output clock only; samples below ignore it
  assign clock_phase = phase_q;
  assign lsb_first = order_q;
  assign chan_powerdown = pd_q;
  assign chan_out_reset = ors_q;

  // alternate between the two user words on each sample
  logic alt_q;
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      alt_q <= 1'b0;
    end else if (sample_valid) begin
      alt_q <= test_alternate ? ~alt_q : 1'b0;
    end
  end

  // user word replaces samples in user test mode
  logic [DATA_W-1:0] user_word;
  assign user_word = alt_q ? word2_q[DATA_W-1:0] : word1_q[DATA_W-1:0];

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      out_valid <= 1'b0;
    end else begin
      out_valid <= sample_valid;
    end
  end

  generate
    for (g = 0; g < CHANNELS; g++) begin : g_out
      logic [DATA_W-1:0] pick;
      assign pick = (test_mode == `TEST_USER) ? user_word
                  : sample_data[g*DATA_W +: DATA_W];
      // reversal when LSB first, zero while lane held
      always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
          out_data[g*DATA_W +: DATA_W] <= '0;
        end else if (ors_q[g] || pd_q[g]) begin
          out_data[g*DATA_W +: DATA_W] <= '0;
        end else if (sample_valid) begin
          out_data[g*DATA_W +: DATA_W] <= order_q ? flip(pick) : pick;
        end
      end
    end
  endgenerate

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n_q);

  term_write_a: assert property (
    reg_wr && hit(reg_addr, `OFS_TERM) |=>
      term_select == $past(reg_wdata[`TERM_MSB:`TERM_LSB]))
    else $error("termination not stored");
  phase_range_a: assert property (
    clock_phase <= `PHASE_MAX) else $error("phase code out of range");
  phase_reset_a: assert property (
    $rose(rst_n_q) |-> clock_phase == `RST_PHASE)
    else $error("phase reset wrong");
  word_store_a: assert property (
    reg_wr && hit(reg_addr, `OFS_W2_HI) |=>
      word2_q[15:8] == $past(reg_wdata))
    else $error("user word not stored");
  order_global_a: assert property (
    sample_valid && lsb_first && test_mode == `TEST_USER &&
    !chan_out_reset[0] && !chan_powerdown[0] ##1 1 |->
      out_data[DATA_W-1:0] == flip($past(user_word)))
    else $error("bit order not applied");
  lane_pd_a: assert property (
    reg_wr && hit(reg_addr, `OFS_LANE) && chan_select[0] |=>
      chan_powerdown[0] == $past(reg_wdata[`LANE_PD_BIT]))
    else $error("power-down not stored");
  lane_hold_a: assert property (
    chan_out_reset[0] |=> out_data[DATA_W-1:0] == '0)
    else $error("output not held in reset");
  user_mux_a: assert property (
    sample_valid && !lsb_first && test_mode == `TEST_USER &&
    !chan_out_reset[0] && !chan_powerdown[0] |=>
      out_data[DATA_W-1:0] == $past(user_word))
    else $error("user word not on output");
  lane_local_a: assert property (
    reg_wr && hit(reg_addr, `OFS_LANE) && !chan_select[0] |=>
      $stable(chan_powerdown[0]) && $stable(chan_out_reset[0]))
    else $error("unselected channel changed");

endmodule

// File: dv/cfg_host.sv
/*
  host model driving the register strobe port.
  assumes one shared clock and calls made after reset release.
*/
`timescale 1ns/100ps
module cfg_host
  import adc_cfg_pkg::*;
(
  // clock
  input wire logic clock,
  // strobe port
  output logic reg_wr,
  output logic reg_rd,
  output reg_addr_t reg_addr,
  output reg_byte_t reg_wdata,
  input wire reg_byte_t reg_rdata,
  input wire logic reg_rvalid
);
  // idle port at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // one write; data inverted after release so stale bytes never help
  task wr(input reg_addr_t a, input reg_byte_t d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask

  // one read; answer sampled half a cycle after the taking edge
  task rd(input reg_addr_t a, output reg_byte_t d, output logic v);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    v = reg_rvalid;
    d = reg_rdata;
  endtask
endmodule

// File: dv/adc_output_config_regs_bench.sv
/*
  self-checking bench for the output configuration register bank.
  assumes the host model above and the design on one 100 MHz clock.
*/
`timescale 1ns/100ps
module adc_output_config_regs_bench
  import adc_cfg_pkg::*;
;
  logic clock, arst_n, reg_wr, reg_rd, reg_rvalid, test_alternate;
  logic sample_valid, lsb_first, out_valid;
  reg_addr_t reg_addr;
  reg_byte_t reg_wdata, reg_rdata;
  logic [3:0] chan_select, test_mode, chan_powerdown, chan_out_reset;
  logic [47:0] sample_data, out_data;
  term_code_t term_select;
  phase_code_t clock_phase;
  int fail_count = 0;
  int total_checks = 0;
  localparam logic [47:0] D = 48'h123456789ABC;

  // design and host
  adc_output_config_regs u_adc_output_config_regs(.clock(clock),
    .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .chan_select(chan_select),
    .test_mode(test_mode), .test_alternate(test_alternate),
    .sample_valid(sample_valid), .sample_data(sample_data),
    .term_select(term_select), .clock_phase(clock_phase),
    .lsb_first(lsb_first), .chan_powerdown(chan_powerdown),
    .chan_out_reset(chan_out_reset), .out_valid(out_valid),
    .out_data(out_data));
  cfg_host u_cfg_host(.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));

  // free-running clock
  always #5 clock = ~clock;

  task chk_b(input logic [8:0] g, input logic [8:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task chk_w(input logic [47:0] g, input logic [47:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // read and compare, valid bit included
  task rdc(input reg_addr_t a, input reg_byte_t e);
    reg_byte_t d;
    logic v;
    u_cfg_host.rd(a, d, v);
    chk_b({v, d}, {1'b1, e});
  endtask

  // one sample set in, output word checked a cycle later
  task smp(input logic [47:0] x, input logic [47:0] e);
    @(negedge clock);
    sample_data = x;
    sample_valid = 1'b1;
    @(negedge clock);
    sample_valid = 1'b0;
    chk_b({8'h00, out_valid}, 9'h001);
    chk_w(out_data, e);
  endtask

  // each 12-bit channel word mirrored
  function automatic logic [47:0] rev(input logic [47:0] x);
    logic [47:0] r;
    for (int i = 0; i < 48; i++) r[i] = x[(i / 12) * 12 + 11 - i % 12];
    return r;
  endfunction

  task t_reset;
    rdc(8'h15, 8'h00);
    rdc(8'h16, 8'h03);
    for (int i = 8'h19; i <= 8'h1C; i++) rdc(i[7:0], 8'h00);
    rdc(8'h21, 8'h00);
    rdc(8'h22, 8'h00);
    rdc(8'h40, 8'h00);
    chk_b({5'h00, clock_phase}, 9'h003);
  endtask

  task t_phase;
    for (int i = 0; i <= 10; i++) begin
      u_cfg_host.wr(8'h16, i[7:0]);
      chk_b({5'h00, clock_phase}, i[8:0]);
    end
    // out-of-range code must leave the last setting
    u_cfg_host.wr(8'h16, 8'h0B);
    chk_b({5'h00, clock_phase}, 9'h00A);
    smp(D, D);
  endtask

  task t_words;
    u_cfg_host.wr(8'h19, 8'hBC);
    u_cfg_host.wr(8'h1A, 8'h5A);
    u_cfg_host.wr(8'h1B, 8'h21);
    u_cfg_host.wr(8'h1C, 8'h03);
    rdc(8'h19, 8'hBC);
    rdc(8'h1A, 8'h5A);
    rdc(8'h1B, 8'h21);
    rdc(8'h1C, 8'h03);
    test_mode = 4'h8;
    smp(D, {4{12'hABC}});
    test_alternate = 1'b1;
    smp(D, {4{12'hABC}});
    smp(D, {4{12'h321}});
    test_alternate = 1'b0;
    test_mode = 4'h0;
  endtask

  task t_order;
    u_cfg_host.wr(8'h21, 8'h80);
    rdc(8'h21, 8'h80);
    chk_b({8'h00, lsb_first}, 9'h001);
    smp(D, rev(D));
    // user words are reversed too
    test_mode = 4'h8;
    smp(D, rev({4{12'hABC}}));
    test_mode = 4'h0;
    u_cfg_host.wr(8'h21, 8'h00);
    chk_b({8'h00, lsb_first}, 9'h000);
  endtask

  task t_lane;
    chan_select = 4'h2;
    u_cfg_host.wr(8'h22, 8'h03);
    chk_b({5'h00, chan_powerdown}, 9'h002);
    chk_b({5'h00, chan_out_reset}, 9'h002);
    rdc(8'h22, 8'h03);
    smp(D, D & ~(48'hFFF << 12));
    chan_select = 4'h1;
    rdc(8'h22, 8'h00);
    // channel 0 alone: output reset without power-down
    u_cfg_host.wr(8'h22, 8'h02);
    chk_b({chan_powerdown, 1'b0, chan_out_reset}, 9'h043);
    smp(D, D & ~48'hFFFFFF);
    chan_select = 4'h3;
    u_cfg_host.wr(8'h22, 8'h00);
    chk_b({chan_powerdown, 1'b0, chan_out_reset}, 9'h000);
  endtask

  task t_term;
    u_cfg_host.wr(8'h15, 8'h30);
    chk_b({7'h00, term_select}, 9'h003);
    rdc(8'h15, 8'h30);
  endtask

  // mid-run reset brings phase and termination back to their defaults
  task t_rerst;
    u_cfg_host.wr(8'h16, 8'h05);
    @(negedge clock);
    arst_n = 1'b0;
    @(negedge clock);
    chk_b({5'h00, clock_phase}, 9'h003);
    chk_b({7'h00, term_select}, 9'h000);
    arst_n = 1'b1;
    repeat (3) @(negedge clock);
    rdc(8'h16, 8'h03);
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // reset for five cycles, then each scenario in turn
  initial begin
    clock = 1'b0;
    arst_n = 1'b0;
    chan_select = 4'h0;
    test_mode = 4'h0;
    test_alternate = 1'b0;
    sample_valid = 1'b0;
    sample_data = 48'h0;
    repeat (5) @(negedge clock);
    arst_n = 1'b1;
    repeat (3) @(negedge clock);
    t_reset;
    t_phase;
    t_words;
    t_order;
    t_lane;
    t_term;
    t_rerst;
    close_out;
  end
endmodule
